// file: logic/nsr_pkg.sv
// constants for the flash status and interrupt register bank
package nsr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_GEOMETRY = 8'h08;
	localparam logic [7:0] OFS_EN_CLR   = 8'h0C;
	localparam logic [7:0] OFS_EN_SET   = 8'h10;
	localparam logic [7:0] OFS_FLAGS    = 8'h14;
	localparam logic [7:0] OFS_COND     = 8'h18;
	// irq source positions
	localparam int IRQ_READY = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_W     = 2;
	// condition register positions
	localparam int COND_POWER_REDUCED = 0;
	localparam int COND_LOADED        = 1;
	localparam int COND_BAD_COMMAND   = 2;
	localparam int COND_LOCKED        = 3;
	localparam int COND_FLASH_FAULT   = 4;
	localparam int COND_SECURITY      = 8;
	// geometry field positions
	localparam int GEO_COUNT_LSB = 0;
	localparam int GEO_SIZE_LSB  = 16;
	// sleep power reduction setting codes
	localparam logic [1:0] SLEEP_EXIT_ON_ACCESS = 2'h0;
	localparam logic [1:0] SLEEP_EXIT_ON_WAKE   = 2'h1;
	localparam logic [1:0] SLEEP_DISABLED       = 2'h3;
	localparam logic [IRQ_W-1:0] EN_RESET = 2'h0;
endpackage

// file: logic/nsr_regs.sv
// flash controller status, geometry and interrupt register bank on apb
// How it works
// - geometry bits 18:16 give page size code, size is 8 shifted by code.
// - geometry bits 15:0 give number of main flash pages.
// - writing ones to enable-clear drops those enables; zeros do nothing.
// - writing ones to enable-set raises those enables; zeros do nothing.
// - both enable registers read one shared enable set, reset zero.
// - error source is bit 1, ready source bit 0, others read zero.
// - error flag sets on flash fault, lock violation or bad command.
// - error flag stays until software writes one to it.
// - ready flag reads zero while busy, one when ready.
// - condition bit 8 shows security active.
// - condition bit 4 sticky flash fault, cleared by writing one.
// - condition bit 3 sticky locked region violation, write one clears.
// - condition bit 2 sticky bad command fault, write one clears.
// - bit 1 set on buffer load, cleared by page write, buffer clear, or write one.
// - bit 0 shows power reduced, entered by command or on sleep entry.
// - power reduction left on flash access, commands, or sleep exit when set.
// - sleep setting 0 exits on access, 1 on wake, 3 disables auto reduction.
`timescale 1ns/1ps
`default_nettype none
module nsr_regs #(
	parameter logic [2:0]  PAGE_SIZE_CODE = 3'h3,
	parameter logic [15:0] PAGE_COUNT     = 16'h0100
) (
	input  wire logic                      pclk,                          // system clock
	input  wire logic                      presetn,                       // async reset, low
	input  wire logic                      psel,                          // apb select
	input  wire logic                      penable,                       // apb access phase
	input  wire logic                      pwrite,                        // apb direction
	input  wire logic [nsr_pkg::ADDR_W-1:0] paddr,                        // apb byte address
	input  wire logic [31:0]               pwdata,                        // apb write data
	output logic      [31:0]               prdata,                        // apb read data
	output logic                           pready,                        // apb ready
	output logic                           pslverr,                       // apb error
	input  wire logic                      ctrl_busy,                     // controller busy
	input  wire logic                      flash_fault_evt,               // flash error pulse
	input  wire logic                      lock_violation_evt,            // locked write pulse
	input  wire logic                      bad_command_evt,               // bad command pulse
	input  wire logic                      buffer_load_evt,               // word loaded pulse
	input  wire logic                      page_write_evt,                // page write cmd pulse
	input  wire logic                      page_buffer_clear_cmd,         // buffer clear pulse
	input  wire logic                      enter_power_reduction_cmd,     // set reduction pulse
	input  wire logic                      leave_power_reduction_cmd,     // clear reduction pulse
	input  wire logic                      flash_access_evt,              // bus access to flash
	input  wire logic                      sleep_enter_evt,               // sleep entry pulse
	input  wire logic                      sleep_exit_evt,                // sleep exit pulse
	input  wire logic [1:0]                sleep_power_reduction_setting, // sleep setting
	input  wire logic                      security_active,               // security level
	output logic                           irq,                           // interrupt request
	output logic                           power_reduced_state            // reduction state
);
	import nsr_pkg::*;

	// refuse settings the logic cannot serve
	if (ADDR_W < 5) begin : g_bad_addr_w
		$error("address bus too narrow for the register map");
	end
	if (IRQ_W != 2) begin : g_bad_irq_w
		$error("interrupt logic serves exactly two sources");
	end
	if (IRQ_ERROR >= IRQ_W || IRQ_READY >= IRQ_W) begin : g_bad_irq_pos
		$error("interrupt source outside the enable field");
	end
	if (COND_SECURITY > 31 || COND_FLASH_FAULT != COND_LOADED + 3) begin : g_bad_cond_pos
		$error("condition fields do not fit the sticky bit loop");
	end
	if (GEO_SIZE_LSB + 3 > 32 || GEO_COUNT_LSB + 16 > GEO_SIZE_LSB) begin : g_bad_geo_pos
		$error("geometry fields overlap or leave the data word");
	end
	if (PAGE_COUNT == 16'h0000) begin : g_bad_count
		$error("page count of zero describes no flash");
	end

	// every bit of state in one record
	typedef struct packed {
		logic [31:0]      rdata;                   // read data for the access cycle
		logic             ready;                   // pready, one cycle after setup
		logic             slverr;                  // pslverr, valid with ready
		logic [IRQ_W-1:0] enable;                  // shared interrupt enables
		logic             err_flag;                // sticky error interrupt flag
		logic             ready_flag;              // controller idle mirror
		logic             flash_fault;             // sticky flash fault
		logic             locked_region_violation; // sticky lock violation
		logic             bad_command_fault;       // sticky bad command
		logic             loaded;                  // page buffer holds words
		logic             power_reduced;           // power reduction state
		logic             secure;                  // security mirror
		logic             irq;                     // interrupt request
	} nsr_state_t;

	nsr_state_t cur;      // registered state
	nsr_state_t next_cur; // next state

	// bus decode
	logic             setup;       // setup cycle of any transfer
	logic             wr;          // write that lands at this edge
	logic             wr_en_clr;   // write to the enable-clear view
	logic             wr_en_set;   // write to the enable-set view
	logic             wr_flags;    // write to the flag register
	logic             wr_cond;     // write to the condition register
	logic [IRQ_W-1:0] en_ones;     // ones written to an enable view
	logic             flag_clr;    // write-one clear of the error flag

	// event side
	logic             any_err;     // any of the three error events
	logic [3:0]       sticky_now;  // condition bits 4:1 as registered
	logic [3:0]       sticky_evt;  // set events of condition bits 4:1
	logic [3:0]       sticky_clr;  // write-one clears of condition bits 4:1
	logic [3:0]       sticky_drop; // hardware clears of condition bits 4:1
	logic [3:0]       sticky_next; // next value of condition bits 4:1
	logic             auto_active; // sleep setting allows automatic entry
	logic             pr_exit;     // any cause to leave power reduction
	logic             pr_enter;    // any cause to enter power reduction

	// read views
	logic [31:0]      geo_word;    // geometry view
	logic [31:0]      en_word;     // shared enable view

	// apb setup phase is where the slave registers the answer
	assign setup = psel && !penable;
	// a write lands only in the access cycle that carries pready
	assign wr = psel && penable && pwrite && pready;

	// one select per writable register
	assign wr_en_clr = wr && (paddr == OFS_EN_CLR);
	assign wr_en_set = wr && (paddr == OFS_EN_SET);
	assign wr_flags  = wr && (paddr == OFS_FLAGS);
	assign wr_cond   = wr && (paddr == OFS_COND);

	// write data fields, unused bits of the word are dropped
	assign en_ones  = pwdata[IRQ_W-1:0];
	assign flag_clr = wr_flags && pwdata[IRQ_ERROR];

	// error events feed the one shared error flag
	assign any_err = flash_fault_evt || lock_violation_evt || bad_command_evt;

	// sticky condition bits 4:1 as one vector, bit k is condition bit k+1
	assign sticky_now  = {cur.flash_fault, cur.locked_region_violation, cur.bad_command_fault, cur.loaded};
	assign sticky_evt  = {flash_fault_evt, lock_violation_evt, bad_command_evt, buffer_load_evt};
	assign sticky_drop = {3'h0, page_write_evt || page_buffer_clear_cmd};

	// per-bit sticky logic: clears first, a same-cycle set event wins
	for (genvar k = 0; k < 4; k++) begin : g_sticky
		assign sticky_clr[k]  = wr_cond && pwdata[COND_LOADED + k];
		assign sticky_next[k] = sticky_evt[k] || (sticky_now[k] && !sticky_clr[k] && !sticky_drop[k]);
	end

	// automatic entry needs one of the two active sleep settings
	assign auto_active = (sleep_power_reduction_setting == SLEEP_EXIT_ON_ACCESS)
		|| (sleep_power_reduction_setting == SLEEP_EXIT_ON_WAKE);
	// leaving causes: command, flash access or wake, per sleep setting
	assign pr_exit = leave_power_reduction_cmd
		|| (flash_access_evt && sleep_power_reduction_setting == SLEEP_EXIT_ON_ACCESS)
		|| (sleep_exit_evt && sleep_power_reduction_setting == SLEEP_EXIT_ON_WAKE);
	// entering causes: command, or sleep entry with an active setting
	assign pr_enter = enter_power_reduction_cmd || (sleep_enter_evt && auto_active);

	// geometry view: size code and page count, other bits low
	assign geo_word = (32'(PAGE_SIZE_CODE) << GEO_SIZE_LSB)
		| (32'(PAGE_COUNT) << GEO_COUNT_LSB);
	// enable view is the same for both enable registers
	assign en_word = {{(32 - IRQ_W){1'b0}}, cur.enable};

	// flag view: error and ready flags at their source positions
	function automatic logic [31:0] flag_view(input nsr_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[IRQ_ERROR] = s.err_flag;
		w[IRQ_READY] = s.ready_flag;
		return w;
	endfunction

	// condition view: security, sticky bits and power state, others low
	function automatic logic [31:0] cond_view(input nsr_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[COND_SECURITY]      = s.secure;
		w[COND_FLASH_FAULT]   = s.flash_fault;
		w[COND_LOCKED]        = s.locked_region_violation;
		w[COND_BAD_COMMAND]   = s.bad_command_fault;
		w[COND_LOADED]        = s.loaded;
		w[COND_POWER_REDUCED] = s.power_reduced;
		return w;
	endfunction

	// next state of the whole bank
	always_comb begin
		next_cur = cur;

		// bus answer: pready one cycle after setup, error only with it
		next_cur.ready = setup;
		if (!setup) begin
			next_cur.slverr = 1'b0;
		end

		// enable bits are shared by set and clear views
		if (wr_en_clr) begin
			next_cur.enable = cur.enable & ~en_ones;
		end
		if (wr_en_set) begin
			next_cur.enable = cur.enable | en_ones;
		end

		// error flag: clear by writing one, a same-cycle event wins
		if (flag_clr) begin
			next_cur.err_flag = 1'b0;
		end
		if (any_err) begin
			next_cur.err_flag = 1'b1;
		end

		// level mirrors, one cycle behind their inputs
		next_cur.ready_flag = !ctrl_busy;
		next_cur.secure = security_active;

		// sticky condition bits from the per-bit logic
		next_cur.flash_fault = sticky_next[COND_FLASH_FAULT - COND_LOADED];
		next_cur.locked_region_violation = sticky_next[COND_LOCKED - COND_LOADED];
		next_cur.bad_command_fault = sticky_next[COND_BAD_COMMAND - COND_LOADED];
		next_cur.loaded = sticky_next[0];

		// power reduction: leaving first, entering wins when both arrive
		if (pr_exit) begin
			next_cur.power_reduced = 1'b0;
		end
		if (pr_enter) begin
			next_cur.power_reduced = 1'b1;
		end

		// interrupt from the flag and enable values being registered
		next_cur.irq = |({next_cur.err_flag, next_cur.ready_flag} & next_cur.enable);

		// read data and error captured in the setup cycle
		if (setup) begin
			next_cur.rdata = 32'h0000_0000;
			next_cur.slverr = 1'b0;
			case (paddr)
				OFS_GEOMETRY: begin
					next_cur.rdata = geo_word;
					next_cur.slverr = pwrite; // read-only register refuses writes
				end
				OFS_EN_CLR, OFS_EN_SET: begin
					next_cur.rdata = en_word;
				end
				OFS_FLAGS: begin
					next_cur.rdata = flag_view(cur);
				end
				OFS_COND: begin
					next_cur.rdata = cond_view(cur);
				end
				default: begin
					next_cur.slverr = 1'b1; // unmapped address
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from the state
	assign prdata = cur.rdata;
	assign pready = cur.ready;
	assign pslverr = cur.slverr;
	assign irq = cur.irq;
	assign power_reduced_state = cur.power_reduced;
endmodule
`default_nettype wire

// file: verification/nsr_asserts.sv
// port-level assertions for the flash status register bank
`timescale 1ns/1ps
`default_nettype none
module nsr_asserts #(
	parameter logic [2:0]  PAGE_SIZE_CODE = 3'h3,
	parameter logic [15:0] PAGE_COUNT     = 16'h0100
) (
	input wire logic        pclk,                          // system clock
	input wire logic        presetn,                       // async reset, low
	input wire logic        psel,                          // apb select
	input wire logic        penable,                       // apb access phase
	input wire logic        pwrite,                        // apb direction
	input wire logic        ctrl_busy,                     // controller busy
	input wire logic [7:0]  paddr,                         // byte address
	input wire logic [31:0] prdata,                        // read data
	input wire logic        enter_power_reduction_cmd,     // enter command
	input wire logic        leave_power_reduction_cmd,     // leave command
	input wire logic        sleep_enter_evt,               // sleep entry
	input wire logic        power_reduced_state,           // reduction state
	input wire logic [1:0]  sleep_power_reduction_setting  // sleep setting
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// read setup cycle at one address
	sequence rd(logic [7:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	geo_value_a: assert property (rd(8'h08) |=> prdata == {13'h0, PAGE_SIZE_CODE, PAGE_COUNT})
		else $error("geometry read wrong");
	ready_flag_a: assert property (rd(8'h14) ##0 $past(presetn) |=> prdata[0] == !$past(ctrl_busy, 2))
		else $error("ready flag wrong");
	flag_unused_a: assert property (rd(8'h14) |=> prdata[31:2] == 30'h0)
		else $error("flag unused bits set");
	en_unused_a: assert property (rd(8'h10) |=> prdata[31:2] == 30'h0)
		else $error("enable unused bits set");
	cond_state_a: assert property (rd(8'h18) |=> prdata[0] == $past(power_reduced_state))
		else $error("power bit differs from state");
	enter_pr_a: assert property (enter_power_reduction_cmd |=> power_reduced_state)
		else $error("enter command ignored");
	leave_pr_a: assert property (leave_power_reduction_cmd && !enter_power_reduction_cmd && !sleep_enter_evt
		|=> !power_reduced_state) else $error("leave command ignored");
	sleep_entry_a: assert property (sleep_enter_evt && sleep_power_reduction_setting inside {2'h0, 2'h1}
		|=> power_reduced_state) else $error("sleep entry ignored");
	sleep_off_a: assert property (sleep_enter_evt && sleep_power_reduction_setting == 2'h3
		&& !enter_power_reduction_cmd && !power_reduced_state |=> !power_reduced_state) else $error("auto entry");
endmodule
bind nsr_regs nsr_asserts #(.PAGE_SIZE_CODE(PAGE_SIZE_CODE), .PAGE_COUNT(PAGE_COUNT)) u_chk (.*);
`default_nettype wire

// file: verification/nsr_regs_tb.sv
// self-checking bench for the flash status register bank
`timescale 1ns/1ps
`default_nettype none
module nsr_regs_tb;
	import nsr_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, busy = 0, sec = 0, err;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic        pready, pslverr, irq, prs;
	logic [10:0] ev = 0;
	logic [1:0]  sps = 0;
	int          num_errors = 0, num_checks = 0;
	always #5 pclk = ~pclk;
	nsr_regs #(.PAGE_SIZE_CODE(3'h7), .PAGE_COUNT(16'hA5C3)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ctrl_busy(busy), .flash_fault_evt(ev[0]), .lock_violation_evt(ev[1]),
		.bad_command_evt(ev[2]), .buffer_load_evt(ev[3]), .page_write_evt(ev[4]), .page_buffer_clear_cmd(ev[5]),
		.enter_power_reduction_cmd(ev[6]), .leave_power_reduction_cmd(ev[7]), .flash_access_evt(ev[8]),
		.sleep_enter_evt(ev[9]), .sleep_exit_evt(ev[10]), .sleep_power_reduction_setting(sps),
		.security_active(sec), .irq(irq), .power_reduced_state(prs));
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) num_errors++;
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask
	// one-cycle event pulse
	task pulse(input int i);
		@(posedge pclk) ev[i] <= 1'b1;
		@(posedge pclk) ev <= 11'h0;
		@(posedge pclk);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(OFS_GEOMETRY, {13'h0, 3'h7, 16'hA5C3}, "geometry");
		apb(1'b1, OFS_GEOMETRY, 32'hFFFFFFFF);
		chk(err, 1, "geometry write");
		rchk(OFS_EN_SET, 0, "enable reset");
		apb(1'b1, OFS_EN_SET, 32'hFFFFFFFF);
		rchk(OFS_EN_CLR, 3, "enable set");
		apb(1'b1, OFS_EN_CLR, 32'h1);
		rchk(OFS_EN_SET, 2, "enable clear");
		apb(1'b1, OFS_EN_SET, 32'h0);
		apb(1'b1, OFS_EN_CLR, 32'h0);
		rchk(OFS_EN_CLR, 2, "zero writes");
		$display("enable test done");
		// each error source sets flag and its own status bit
		for (int i = 0; i < 3; i++) begin
			pulse(i);
			chk(irq, 1, "error irq");
			rchk(OFS_FLAGS, 3, "error flag");
			rchk(OFS_COND, 32'h10 >> i, "error status");
			apb(1'b1, OFS_FLAGS, 32'h1);
			rchk(OFS_FLAGS, 3, "flag kept");
			apb(1'b1, OFS_FLAGS, 32'h2);
			apb(1'b1, OFS_COND, 32'h1C);
			rchk(OFS_COND, 0, "status cleared");
			chk(irq, 0, "irq off");
		end
		busy <= 1'b1;
		apb(1'b1, OFS_EN_SET, 32'h1);
		rchk(OFS_FLAGS, 0, "busy flag");
		chk(irq, 0, "busy irq");
		busy <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(irq, 1, "ready irq");
		apb(1'b1, OFS_EN_CLR, 32'h3);
		$display("flag test done");
		// loaded bit cleared by page write, buffer clear, write one
		for (int i = 4; i < 7; i++) begin
			pulse(3);
			rchk(OFS_COND, 2, "loaded");
			if (i < 6) pulse(i);
			else apb(1'b1, OFS_COND, 32'h2);
			rchk(OFS_COND, 0, "unloaded");
		end
		sec <= 1'b1;
		rchk(OFS_COND, 32'h100, "security");
		sec <= 1'b0;
		pulse(6);
		rchk(OFS_COND, 1, "reduced");
		pulse(8);
		chk(prs, 0, "access exit");
		sps <= SLEEP_EXIT_ON_WAKE;
		pulse(9);
		chk(prs, 1, "sleep entry");
		pulse(8);
		chk(prs, 1, "access kept");
		pulse(10);
		chk(prs, 0, "wake exit");
		sps <= SLEEP_DISABLED;
		pulse(9);
		chk(prs, 0, "auto disabled");
		pulse(6);
		pulse(7);
		chk(prs, 0, "leave command");
		sps <= 2'h2;
		pulse(9);
		chk(prs, 0, "reserved setting");
		// mid-run reset clears enables and sticky flags
		apb(1'b1, OFS_EN_SET, 32'h2);
		pulse(0);
		chk(irq, 1, "irq before reset");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(irq, 0, "irq in reset");
		presetn <= 1'b1;
		rchk(OFS_FLAGS, 1, "flags after reset");
		rchk(OFS_COND, 0, "status after reset");
		rchk(OFS_EN_SET, 0, "enable after reset");
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1, "unmapped");
		$display("status test done");
		give_verdict;
	end
endmodule
`default_nettype wire
